//--- verilog/lpfm_defs.svh
`ifndef LPFM_DEFS_SVH
`define LPFM_DEFS_SVH

// =====================================================
// clock
`define CLK_HZ 20000000
`define CLK_MHZ 20

// =====================================================
// polarity glitch filter
`define POL_FILT_SHORT_US 50
`define POL_FILT_LONG_US 200
`define POL_FILT_SHORT_CYC (`POL_FILT_SHORT_US * `CLK_MHZ)
`define POL_FILT_LONG_CYC (`POL_FILT_LONG_US * `CLK_MHZ)

// =====================================================
// frequency window, half-line interval limits
`define UPPER_FREQ_LIMIT_HZ 72
`define LOWER_FREQ_LIMIT_HZ 42
`define IVL_MIN_CYC ((`CLK_HZ + 2 * `UPPER_FREQ_LIMIT_HZ - 1) / (2 * `UPPER_FREQ_LIMIT_HZ))
`define IVL_MAX_CYC (`CLK_HZ / (2 * `LOWER_FREQ_LIMIT_HZ))
`define FREQ_FAULT_DELAY_MS 100
`define FREQ_FAULT_DELAY_CYC ((`CLK_HZ / 1000) * `FREQ_FAULT_DELAY_MS)
`define VALID_EDGES_NEEDED 3'h4

// =====================================================
// register map
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define CTRL_MON_EN_BIT 0
`define CTRL_RESET 8'h01

`endif

//--- verilog/lpfm_pkg.sv
package lpfm_pkg;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_DELAY = 2'b01,
    ST_FAULT = 2'b10
  } freq_state_t;

  typedef struct packed {
    logic var_s1;
    logic var_s2;
    logic raw;
    logic pol;
    logic [11:0] filt_cnt;
    logic have_ref;
    logic [17:0] ivl_cnt;
    logic [20:0] dly_cnt;
    logic [2:0] valid_edge_count;
    freq_state_t fsm;
    logic good;
    logic running;
    logic sr_low;
    logic sr_high;
    logic fast_en;
    logic mon_en;
    logic [7:0] rdata;
  } mon_state_t;

endpackage

//--- verilog/line_polarity_frequency_monitor.sv
// Summary of operation
// - polarity is the direct comparison of the two line-sense inputs
// - polarity glitch filter time is 50 or 200 us per variant strap
// - filtered output follows raw only after raw held longer than filter time
// - raw returning early keeps output and restarts the filter timer
// - optional supervision checks polarity toggles fit 42 to 72 Hz mains
// - time every interval between successive filtered polarity edges
// - out-of-range interval drops slow-leg drives and starts 100 ms timer
// - in-range interval before expiry clears timer, re-enables slow legs
// - timer expiry drops fast-leg drives and enters frequency fault
// - slow-leg drives stay off throughout the frequency fault
// - filter and interval timing keep running during the fault
// - four consecutive in-range edges end the fault, restart as fresh
// - in-range means line frequency between 42 Hz and 72 Hz
// - startup waits for rising polarity and four in-range intervals
// - frequency-good flag sets on the fourth consecutive in-range toggle
// - rising polarity marks positive half cycle, low slow leg conducts
// - startup also needs brown-out cleared and supply above turn-on
// - brown-out timer expiry resets detection and all latched state except control register and strap sampling
`include "lpfm_defs.svh"

module line_polarity_frequency_monitor #(
  parameter int IVL_MIN_CYC = `IVL_MIN_CYC,
  parameter int IVL_MAX_CYC = `IVL_MAX_CYC,
  parameter int DELAY_CYC = `FREQ_FAULT_DELAY_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // sampled line-sense levels, same clock
  input wire logic [9:0] line_sense_inductor_node,
  input wire logic [9:0] line_sense_bridge_node,
  // variant strap pin, high selects the long filter
  input wire logic filter_variant_long,
  // supervision inputs from on-chip logic
  input wire logic brownout_flag,
  input wire logic vcc_above_on,
  input wire logic brownout_timer_expired,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // status and drive gating
  output logic filtered_polarity,
  output logic line_freq_good,
  output logic line_freq_fault,
  output logic drive_running,
  output logic slow_leg_low_drive,
  output logic slow_leg_high_drive,
  output logic fast_leg_drive_en
);
  import lpfm_pkg::*;

  localparam mon_state_t ST_RESET = '{
    fsm: ST_RUN,
    mon_en: 1'b1,
    default: '0
  };

  mon_state_t st_r;
  mon_state_t st_nxt;
  logic [11:0] flim;
  logic pol_edge;
  logic win_ok;
  logic timeout;
  logic ev_valid;
  logic ev_bad;
  logic dly_done;

  function automatic logic in_window(input logic [17:0] cnt);
    in_window = (cnt >= 18'(IVL_MIN_CYC)) && (cnt <= 18'(IVL_MAX_CYC));
  endfunction

  // =====================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    st_nxt.var_s1 = filter_variant_long;
    st_nxt.var_s2 = st_r.var_s1;
    // direct comparison of the two sense levels
    st_nxt.raw = line_sense_inductor_node > line_sense_bridge_node;

    // glitch filter
    flim = st_r.var_s2 ? 12'(`POL_FILT_LONG_CYC) : 12'(`POL_FILT_SHORT_CYC);
    pol_edge = 1'b0;
    if (st_r.raw == st_r.pol) begin
      st_nxt.filt_cnt = 12'h000;
    end else if (st_r.filt_cnt == flim) begin
      st_nxt.pol = st_r.raw;
      st_nxt.filt_cnt = 12'h000;
      pol_edge = 1'b1;
    end else begin
      st_nxt.filt_cnt = st_r.filt_cnt + 12'h001;
    end

    // interval measurement, counter holds cycles since last edge
    win_ok = in_window(st_r.ivl_cnt);
    timeout = !pol_edge && st_r.have_ref && (st_r.ivl_cnt == 18'(IVL_MAX_CYC));
    if (pol_edge) begin
      st_nxt.ivl_cnt = 18'h00001;
      st_nxt.have_ref = 1'b1;
    end else if (st_r.ivl_cnt <= 18'(IVL_MAX_CYC)) begin
      st_nxt.ivl_cnt = st_r.ivl_cnt + 18'h00001;
    end
    ev_valid = pol_edge && st_r.have_ref && (win_ok || !st_r.mon_en);
    ev_bad = st_r.mon_en && ((pol_edge && st_r.have_ref && !win_ok) || timeout);

    // consecutive valid-edge count
    if (ev_bad) begin
      st_nxt.valid_edge_count = 3'h0;
    end else if (ev_valid && st_r.valid_edge_count != `VALID_EDGES_NEEDED) begin
      st_nxt.valid_edge_count = st_r.valid_edge_count + 3'h1;
    end
    st_nxt.good = st_nxt.valid_edge_count == `VALID_EDGES_NEEDED;

    // frequency fault sequence
    dly_done = st_r.dly_cnt == 21'(DELAY_CYC - 1);
    unique case (st_r.fsm)
      ST_RUN: begin
        if (ev_bad) begin
          st_nxt.fsm = ST_DELAY;
          st_nxt.dly_cnt = 21'h000000;
        end
      end
      ST_DELAY: begin
        if (ev_valid) begin
          st_nxt.fsm = ST_RUN;
          st_nxt.dly_cnt = 21'h000000;
        end else if (dly_done) begin
          st_nxt.fsm = ST_FAULT;
          st_nxt.running = 1'b0;
        end else begin
          st_nxt.dly_cnt = st_r.dly_cnt + 21'h000001;
        end
      end
      ST_FAULT: begin
        // filter and timing above keep running here
        if (ev_valid && st_nxt.good) begin
          st_nxt.fsm = ST_RUN;
          st_nxt.dly_cnt = 21'h000000;
        end
      end
      default: begin
        st_nxt.fsm = ST_FAULT;
      end
    endcase
    if (!st_r.mon_en) begin
      st_nxt.fsm = ST_RUN;
    end

    // startup on a rising filtered edge
    if (!st_r.running && pol_edge && st_nxt.pol && st_nxt.good
        && st_nxt.fsm == ST_RUN) begin
      st_nxt.running = !brownout_flag && vcc_above_on;
    end

    // drive gating
    st_nxt.sr_low = st_nxt.running && st_nxt.fsm == ST_RUN && st_nxt.pol;
    st_nxt.sr_high = st_nxt.running && st_nxt.fsm == ST_RUN && !st_nxt.pol;
    st_nxt.fast_en = st_nxt.running && st_nxt.fsm != ST_FAULT;

    // register port
    if (reg_wr && reg_addr == `REG_CTRL) begin
      st_nxt.mon_en = reg_wdata[`CTRL_MON_EN_BIT];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `REG_CTRL: st_nxt.rdata = {7'h00, st_r.mon_en};
        `REG_STATUS: st_nxt.rdata = {st_r.valid_edge_count, st_r.running,
                                     st_r.fsm == ST_DELAY, st_r.fsm == ST_FAULT,
                                     st_r.good, st_r.pol};
        default: st_nxt.rdata = 8'h00;
      endcase
    end

    // brown-out timer expiry restarts everything but control and strap
    if (brownout_timer_expired) begin
      st_nxt = ST_RESET;
      st_nxt.mon_en = st_r.mon_en;
      st_nxt.var_s1 = filter_variant_long;
      st_nxt.var_s2 = st_r.var_s1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign filtered_polarity = st_r.pol;
  assign line_freq_good = st_r.good;
  assign line_freq_fault = st_r.fsm == ST_FAULT;
  assign drive_running = st_r.running;
  assign slow_leg_low_drive = st_r.sr_low;
  assign slow_leg_high_drive = st_r.sr_high;
  assign fast_leg_drive_en = st_r.fast_en;

  // =====================================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst || brownout_timer_expired);

  sequence s_bad_in_run;
    st_r.fsm == ST_RUN && ev_bad;
  endsequence

  sequence s_valid_in_delay;
    st_r.fsm == ST_DELAY && ev_valid;
  endsequence

  property p_cmp;
    1'b1 |=> st_r.raw == $past(line_sense_inductor_node > line_sense_bridge_node);
  endproperty
  a_cmp: assert property (p_cmp) else $error("raw polarity mismatch");

  property p_filt_change;
    $changed(st_r.pol) |-> $past(st_r.filt_cnt) == $past(flim)
      && $past(st_r.raw) != $past(st_r.pol);
  endproperty
  a_filt_change: assert property (p_filt_change) else $error("early polarity change");

  property p_filt_restart;
    st_r.raw == st_r.pol |=> st_r.filt_cnt == 12'h000;
  endproperty
  a_filt_restart: assert property (p_filt_restart) else $error("filter timer kept");

  property p_bad_drops_slow;
    s_bad_in_run |=> st_r.fsm == ST_DELAY ##1 !slow_leg_low_drive && !slow_leg_high_drive;
  endproperty
  a_bad_drops_slow: assert property (p_bad_drops_slow) else $error("slow legs not dropped");

  property p_valid_recovers;
    s_valid_in_delay |=> st_r.fsm == ST_RUN && st_r.dly_cnt == 21'h000000;
  endproperty
  a_valid_recovers: assert property (p_valid_recovers) else $error("delay not cleared");

  property p_expiry_fault;
    st_r.fsm == ST_DELAY && !ev_valid && dly_done |=> line_freq_fault ##1 !fast_leg_drive_en;
  endproperty
  a_expiry_fault: assert property (p_expiry_fault) else $error("no fault on expiry");

  property p_fault_slow_off;
    line_freq_fault && $past(line_freq_fault) |-> !slow_leg_low_drive && !slow_leg_high_drive;
  endproperty
  a_fault_slow_off: assert property (p_fault_slow_off) else $error("slow leg during fault");

  property p_bad_clears_count;
    ev_bad |=> st_r.valid_edge_count == 3'h0 && !line_freq_good;
  endproperty
  a_bad_clears_count: assert property (p_bad_clears_count) else $error("count not cleared");

  property p_good_on_fourth;
    ev_valid && !ev_bad && st_r.valid_edge_count == 3'h3 |=> line_freq_good;
  endproperty
  a_good_on_fourth: assert property (p_good_on_fourth) else $error("good not set");

  property p_start_rising;
    $rose(drive_running) |-> $rose(filtered_polarity) && line_freq_good
      && $past(vcc_above_on) && !$past(brownout_flag);
  endproperty
  a_start_rising: assert property (p_start_rising) else $error("startup not on rising edge");

endmodule

//--- testbench/line_divider_model.sv
// ========
// divided line nodes of a floating mains source
module line_divider_model (
  // clock
  input wire logic clock,
  // half period in cycles, 0 holds the line still
  input wire logic [15:0] half_cyc,
  input wire logic invert,
  // divided nodes
  output logic [9:0] ind_node,
  output logic [9:0] brg_node
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pos = 1'b0;
  logic [15:0] cnt = 16'h0;
  always @(posedge clock) begin
    if (half_cyc != 16'h0 && cnt + 16'h1 >= half_cyc) begin
      cnt <= 16'h0;
      pos <= !pos;
    end else begin
      cnt <= cnt + 16'h1;
    end
  end
  // nodes cross over at each polarity change
  assign ind_node = (pos ^ invert) ? 10'h1f4 : 10'h000;
  assign brg_node = (pos ^ invert) ? 10'h000 : 10'h0fa;
endmodule

//--- testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // signals
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [9:0] ind_node, brg_node;
  logic [15:0] half_cyc = 16'h0;
  logic invert = 1'b0;
  logic bo_flag = 1'b1;
  logic vcc_on = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic pol, good, fault, running, sr_low, sr_high, fast;
  int err_count = 0;
  int compares = 0;
  always #25 clock = ~clock;
  line_divider_model line (.clock(clock), .half_cyc(half_cyc), .invert(invert),
    .ind_node(ind_node), .brg_node(brg_node));
  line_polarity_frequency_monitor #(.IVL_MIN_CYC(1100), .IVL_MAX_CYC(2000),
    .DELAY_CYC(5000)) dut (.clock(clock), .srst(srst),
    .line_sense_inductor_node(ind_node), .line_sense_bridge_node(brg_node),
    .filter_variant_long(1'b0), .brownout_flag(bo_flag), .vcc_above_on(vcc_on),
    .brownout_timer_expired(1'b0), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .filtered_polarity(pol), .line_freq_good(good), .line_freq_fault(fault),
    .drive_running(running), .slow_leg_low_drive(sr_low),
    .slow_leg_high_drive(sr_high), .fast_leg_drive_en(fast));
  // ========
  // tasks
  task automatic check_bit(input string name, input logic exp, input logic got);
    @(negedge clock);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    check_byte("reg_rdata", exp, reg_rdata);
  endtask
  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ========
  // scenarios
  task automatic t_regs;
    reg_read(4'h0, 8'h01);
    reg_read(4'h1, 8'h00);
    reg_write(4'h9, 8'hff);
    reg_read(4'h9, 8'h00);
    reg_write(4'h0, 8'h00);
    reg_read(4'h0, 8'h00);
    reg_write(4'h0, 8'h01);
    reg_read(4'h0, 8'h01);
  endtask
  task automatic t_filter;
    cycles(1);
    invert <= 1'b1;
    cycles(500);
    invert <= 1'b0;
    cycles(1100);
    check_bit("glitch", 1'b0, pol);
    cycles(1);
    invert <= 1'b1;
    cycles(990);
    check_bit("early", 1'b0, pol);
    cycles(110);
    check_bit("qualified", 1'b1, pol);
    cycles(1400);
    invert <= 1'b0;
    cycles(1100);
    check_bit("back", 1'b0, pol);
  endtask
  task automatic t_startup;
    half_cyc <= 16'd1500;
    for (int i = 0; i < 12000 && good !== 1'b1; i++) @(negedge clock);
    check_bit("good", 1'b1, good);
    cycles(3200);
    check_bit("held", 1'b0, running);
    cycles(1);
    bo_flag <= 1'b0;
    vcc_on <= 1'b0;
    cycles(3200);
    check_bit("held vcc", 1'b0, running);
    cycles(1);
    vcc_on <= 1'b1;
    for (int i = 0; i < 3200 && running !== 1'b1; i++) @(negedge clock);
    check_bit("running", 1'b1, running);
    check_bit("start pol", 1'b1, pol);
    check_bit("fast", 1'b1, fast);
    check_bit("low leg", 1'b1, sr_low);
    check_bit("high leg", 1'b0, sr_high);
  endtask
  task automatic t_bad;
    cycles(1);
    half_cyc <= 16'd1050;
    cycles(1100);
    half_cyc <= 16'd1500;
    for (int i = 0; i < 3000 && (sr_low | sr_high) !== 1'b0; i++) @(negedge clock);
    check_bit("legs off", 1'b0, sr_low | sr_high);
    check_bit("good cleared", 1'b0, good);
    check_bit("fast kept", 1'b1, fast);
    cycles(3500);
    check_bit("legs back", 1'b1, sr_low | sr_high);
  endtask
  task automatic t_fault;
    cycles(1);
    half_cyc <= 16'd1050;
    for (int i = 0; i < 9000 && fault !== 1'b1; i++) @(negedge clock);
    check_bit("fault", 1'b1, fault);
    check_bit("fast off", 1'b0, fast);
    cycles(2000);
    check_bit("legs in fault", 1'b0, sr_low | sr_high);
    cycles(1);
    half_cyc <= 16'd1500;
    for (int i = 0; i < 9000 && fault !== 1'b0; i++) @(negedge clock);
    check_bit("recovered", 1'b0, fault);
    check_bit("good again", 1'b1, good);
    for (int i = 0; i < 3200 && running !== 1'b1; i++) @(negedge clock);
    check_bit("restart", 1'b1, running);
  endtask
  // ========
  // run
  initial begin
    cycles(10);
    srst <= 1'b0;
    t_regs();
    t_filter();
    t_startup();
    t_bad();
    t_fault();
    end_of_test();
  end
  initial begin
    cycles(80000);
    err_count++;
    end_of_test();
  end
endmodule
